/* File: pmio_core.sv */
/*
  Power-management I/O control: output words, a shared panel and backlight
  inactivity timer, sampled inputs with event flags, NMI and attention.
  Assumes host I/O strobes are one-cycle pulses on core_clk and that the
  external latch takes latch_data on latch_strobe.
*/
// Behaviour
// - Two output words; low bytes read only
// - Outputs 0-7 fixed roles, 8-15 user
// - Timeout clears panel or backlight output
// - Refresh after keyboard interrupt restarts timer
// - One timer shared by both timeouts
// - Timer counts in five-second steps
// - Backlight field: off, timed, always on
// - Panel field: off, timed, always on
// - Update enable gates external latch updates
// - Local enable makes input 2 request
// - Attention flags give attention and flags
// - Writing zero clears flag; one ignored
// - Clearing both enables clears flag
// - Flagged input bit stays frozen
// - Low input bits show sampled inputs
// - NMI enables give NMI on change
// - Attention enables drive attention independently
// - Inputs 2-6 any edge; 7 rising
// - Status shows flags 7-2, rest zero
// - Shadow returns serial and parallel settings
// - External latch cleared after power up
// - Local request, hold, acknowledge handshake
`timescale 1ns/1ps
`default_nettype none

module pmio_core #(
  parameter longint STEP_CYC = pmio_pkg::STEP_CYCLES  // Cycles per step.
) (
  input  wire logic        core_clk,       // Core clock, 100 MHz.
  input  wire logic        rst_n,          // Synchronous reset, active low.
  input  wire logic [15:0] io_addr,        // Host I/O port address.
  input  wire logic        io_wr,          // Host write strobe.
  input  wire logic        io_rd,          // Host read strobe.
  input  wire logic [15:0] io_wdata,       // Host write data.
  output var  logic [15:0] io_rdata,       // Host read data.
  input  wire logic [7:0]  power_in,       // Power-control input pins.
  input  wire logic        kbd_irq,        // Keyboard interrupt pin.
  input  wire logic        hold_acknowledge, // Hold acknowledge pin.
  input  wire logic        refresh_cycle,  // Refresh pulse, same clock.
  input  wire logic        a20_gate,       // Internal A20 gate level.
  input  wire logic [1:0]  serial_a_shadow, // Serial A reg 2 bits 7-6.
  input  wire logic [1:0]  serial_b_shadow, // Serial B reg 2 bits 7-6.
  input  wire logic [3:0]  parallel_reg2_shadow, // Parallel reg 2 3-0.
  input  wire logic [7:0]  parallel_reg0_shadow, // Parallel reg 0.
  output var  logic [7:0]  latch_data,     // External latch data.
  output var  logic        latch_strobe,   // External latch load pulse.
  output var  logic [7:0]  power_out_high, // Outputs 15-8.
  output var  logic        hold_request,   // Hold request to processor.
  output var  logic        nmi,            // Non-maskable interrupt.
  output var  logic        attention_signal // Keyboard attention.
);
  import pmio_pkg::*;

  // Decodes a host access to one port address.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
    hit = (a == p);
  endfunction : hit

  logic [9:0]  sync_w;        // Synchronised pins.
  logic [7:0]  in_now;        // Synchronised power inputs.
  logic        kbd_now;       // Synchronised keyboard interrupt.
  logic        hold_acknowledge_now;      // Synchronised hold acknowledge.
  logic        kbd_prev_r;    // Keyboard level last cycle.
  logic        kbd_seen_r;    // Keyboard interrupt waiting for refresh.
  logic [7:0]  req_low_r;     // Host-requested outputs 7-0.
  logic [7:0]  out_high_r;    // Outputs 15-8.
  logic [15:0] timers_r;      // Backlight and panel timeout fields.
  logic [7:0]  in_ctl_r;      // Input register bits 15-8.
  logic [7:0]  sampled_r;     // Sampled inputs.
  logic [5:0]  flags_r;       // Event flags 7-2.
  logic [5:0]  nmi_en_r;      // NMI enables 7-2.
  logic [5:0]  attn_en_r;     // Attention enables 7-2.
  logic [63:0] pre_r;         // Five-second prescaler.
  logic [7:0]  elapsed_r;     // Inactivity time in steps, saturating.
  logic        panel_on;      // Panel allowed by the timer.
  logic        back_on;       // Backlight allowed by the timer.
  logic [7:0]  out_low;       // Live outputs 7-0.
  logic [7:0]  out_prev_r;    // Outputs 7-0 last cycle.
  logic        clr_pend_r;    // Latch clear still owed after reset.
  pmio_lcl_t   lcl_r;         // Local access state.
  logic [5:0]  edge_ev;       // Input events, inputs 7-2.
  logic [5:0]  flag_set;      // Flags set this cycle.
  logic [5:0]  flag_clr;      // Flags cleared this cycle.
  logic        wr_status;     // Host writes the status port.
  logic        wr_enables;    // Host writes the enables port.

  assign wr_status  = io_wr && hit(io_addr, ADDR_STATUS);
  assign wr_enables = io_wr && hit(io_addr, ADDR_ENABLES);

  // Pin inputs pass the three-stage synchroniser.
  pmio_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({hold_acknowledge, kbd_irq, power_in}),
    .pin_sync (sync_w)
  );
  assign in_now   = sync_w[7:0];
  assign kbd_now  = sync_w[8];
  assign hold_acknowledge_now = sync_w[9];

  // Host-writable output and control registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_low_r  <= RST_BYTE;
      out_high_r <= RST_BYTE;
      timers_r   <= RST_WORD;
      in_ctl_r   <= RST_BYTE;
      nmi_en_r   <= 6'h00;
      attn_en_r  <= 6'h00;
    end else if (io_wr) begin
      // The low byte of each output word ignores writes; the high byte
      // carries the requested output levels.
      if (hit(io_addr, ADDR_OUT_LOW)) begin
        req_low_r <= io_wdata[15:8];
      end
      if (hit(io_addr, ADDR_OUT_HIGH)) begin
        out_high_r <= io_wdata[15:8];
      end
      if (hit(io_addr, ADDR_TIMERS)) begin
        timers_r <= io_wdata;
      end
      if (hit(io_addr, ADDR_INPUTS)) begin
        in_ctl_r <= io_wdata[15:8];
      end
      // Bits 9-8 and 1-0 of the enables word are not stored.
      if (wr_enables) begin
        nmi_en_r  <= io_wdata[15:10];
        attn_en_r <= io_wdata[7:2];
      end
    end
  end

  // Prescaler gives one tick every five seconds.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_r <= 64'h0000000000000000;
    end else if (refresh_cycle && kbd_seen_r) begin
      // Restart the step together with the count, so the first step is full.
      pre_r <= 64'h0000000000000000;
    end else if (pre_r == 64'(STEP_CYC - 1)) begin
      pre_r <= 64'h0000000000000000;
    end else begin
      pre_r <= pre_r + 64'h0000000000000001;
    end
  end

  // Remember a keyboard interrupt until the next refresh cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      kbd_prev_r <= 1'b0;
      kbd_seen_r <= 1'b0;
    end else begin
      kbd_prev_r <= kbd_now;
      if (kbd_now && !kbd_prev_r) begin
        kbd_seen_r <= 1'b1;
      end else if (refresh_cycle) begin
        kbd_seen_r <= 1'b0;
      end
    end
  end

  // One shared inactivity count in five-second steps; saturates at FF.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      elapsed_r <= RST_BYTE;
    end else if (refresh_cycle && kbd_seen_r) begin
      elapsed_r <= RST_BYTE;
    end else if (pre_r == 64'(STEP_CYC - 1) && elapsed_r != TMO_ALWAYS) begin
      elapsed_r <= elapsed_r + 8'h01;
    end
  end

  // Compare the same elapsed time with each limit.
  always_comb begin
    back_on  = (timers_r[15:8] == TMO_ALWAYS) ||
               ((timers_r[15:8] != TMO_OFF) &&
                (elapsed_r < timers_r[15:8]));
    panel_on = (timers_r[7:0] == TMO_ALWAYS) ||
               ((timers_r[7:0] != TMO_OFF) &&
                (elapsed_r < timers_r[7:0]));
  end

  // Local access handshake: request hold, acknowledge, release.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lcl_r <= LCL_IDLE;
    end else begin
      unique case (lcl_r)
        // Input 2 is a request only while local access is enabled.
        LCL_IDLE: begin
          if (in_ctl_r[IN_LOCAL_EN - 8] && in_now[IN_LOCAL_REQ]) begin
            lcl_r <= LCL_HOLD;
          end
        end
        // Wait for the processor to grant the bus.
        LCL_HOLD: begin
          if (hold_acknowledge_now) begin
            lcl_r <= LOCAL_ACKNOWLEDGE;
          end
        end
        // Hold acknowledge until the controller drops its request.
        LOCAL_ACKNOWLEDGE: begin
          if (!in_now[IN_LOCAL_REQ]) begin
            lcl_r <= LCL_IDLE;
          end
        end
      endcase
    end
  end
  assign hold_request = (lcl_r != LCL_IDLE);

  // Assemble the live low output byte from roles and overrides.
  always_comb begin
    out_low                = req_low_r;
    out_low[OUT_PANEL]     = req_low_r[OUT_PANEL] && panel_on;
    out_low[OUT_BACKLIGHT] = req_low_r[OUT_BACKLIGHT] && back_on;
    out_low[OUT_LOCAL_ACKNOWLEDGE]   = (lcl_r == LOCAL_ACKNOWLEDGE);
    out_low[OUT_LCL_ATTN]  = attention_signal;
    out_low[OUT_A20]       = a20_gate;
  end
  assign power_out_high = out_high_r;

  // Update the external latch on change, and clear it after reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_prev_r   <= RST_BYTE;
      clr_pend_r   <= 1'b1;
      latch_data   <= RST_BYTE;
      latch_strobe <= 1'b0;
    end else begin
      out_prev_r   <= out_low;
      latch_strobe <= 1'b0;
      if (clr_pend_r) begin
        clr_pend_r   <= 1'b0;
        latch_data   <= RST_BYTE;
        latch_strobe <= 1'b1;
      end else if (in_ctl_r[IN_UPDATE_EN - 8] && out_low != out_prev_r) begin
        latch_data   <= out_low;
        latch_strobe <= 1'b1;
      end
    end
  end

  // Detect input events: any change on 2-6, rising edge on 7.
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_evt
      if (g == 5) begin : g_act
        assign edge_ev[g] = in_now[g + 2] && !sampled_r[g + 2];
      end else begin : g_any
        assign edge_ev[g] = in_now[g + 2] != sampled_r[g + 2];
      end
      // A flag needs an enable that watches the input.
      assign flag_set[g] = edge_ev[g] && !flags_r[g] &&
                           (nmi_en_r[g] || attn_en_r[g] || in_ctl_r[g]);
      // Cleared by a zero in the status port or by both enables going zero.
      assign flag_clr[g] = (wr_status && !io_wdata[g + 2]) ||
                           (wr_enables && !io_wdata[g + EN_NMI_LSB] &&
                            !io_wdata[g + EN_ATTN_LSB]);
    end
  endgenerate

  // Sticky event flags; a set in the cycle of a clear wins.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags_r <= 6'h00;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // Sample inputs; a flagged input holds its last sampled value.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sampled_r <= RST_BYTE;
    end else begin
      sampled_r[1:0] <= in_now[1:0];
      for (int i = 0; i < 6; i++) begin
        if (!flags_r[i]) begin
          sampled_r[i + 2] <= in_now[i + 2];
        end
      end
    end
  end

  // NMI and attention are levels while an enabled flag stands.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nmi              <= 1'b0;
      attention_signal <= 1'b0;
    end else begin
      nmi              <= |(flags_r & nmi_en_r);
      attention_signal <= |(flags_r & (attn_en_r | in_ctl_r[5:0]));
    end
  end

  // Registered read data; unmapped ports read zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      io_rdata <= RST_WORD;
    end else if (io_rd) begin
      unique case (io_addr)
        ADDR_OUT_LOW:  io_rdata <= {req_low_r, out_low};
        ADDR_OUT_HIGH: io_rdata <= {out_high_r, out_high_r};
        ADDR_TIMERS:   io_rdata <= timers_r;
        ADDR_INPUTS:   io_rdata <= {in_ctl_r, sampled_r};
        ADDR_STATUS:   io_rdata <= {8'h00, flags_r, 2'b00};
        ADDR_ENABLES:  io_rdata <= {nmi_en_r, 2'b00, attn_en_r, 2'b00};
        ADDR_SHADOW:   io_rdata <= {serial_a_shadow, serial_b_shadow,
                                    parallel_reg2_shadow,
                                    parallel_reg0_shadow};
        default:       io_rdata <= RST_WORD;
      endcase
    end
  end

endmodule : pmio_core

`default_nettype wire

/* File: pmio_core_asserts.sv */
/*
  Checker for pmio_core, bound to every instance.
  Assumes only the top module's ports are visible.
*/
`timescale 1ns/1ps
`default_nettype none

module pmio_core_asserts
  import pmio_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic [1:0]  serial_a_shadow,
  input wire logic [1:0]  serial_b_shadow,
  input wire logic [3:0]  parallel_reg2_shadow,
  input wire logic [7:0]  parallel_reg0_shadow,
  input wire logic [7:0]  latch_data,
  input wire logic        latch_strobe,
  input wire logic        nmi
);
  logic [15:0] en_r;   // Last word written to the enables port.
  logic        upd_r;  // Last latch update enable written.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Tracks the enables the host has written.
  always_ff @(posedge core_clk) begin
    if (!rst_n) en_r <= RST_WORD;
    else if (io_wr && io_addr == ADDR_ENABLES) en_r <= io_wdata;
  end

  // Tracks the latch update enable the host has written.
  always_ff @(posedge core_clk) begin
    if (!rst_n) upd_r <= 1'b0;
    else if (io_wr && io_addr == ADDR_INPUTS) upd_r <= io_wdata[IN_UPDATE_EN];
  end

  a_status_zero: assert property (
    io_rd && io_addr == ADDR_STATUS |=> io_rdata[15:8] == 8'h00 && io_rdata[1:0] == 2'h0)
    else $error("status unused bits not zero");
  a_shadow_fields: assert property (
    io_rd && io_addr == ADDR_SHADOW |=> io_rdata == $past({serial_a_shadow,
      serial_b_shadow, parallel_reg2_shadow, parallel_reg0_shadow}))
    else $error("shadow word wrong");
  a_high_mirror: assert property (
    io_rd && io_addr == ADDR_OUT_HIGH |=> io_rdata[15:8] == io_rdata[7:0])
    else $error("high word halves differ");
  a_low_roles: assert property (
    io_rd && io_addr == ADDR_OUT_LOW |=> io_rdata[0] == io_rdata[8]
      && io_rdata[5] == io_rdata[13] && io_rdata[7] == io_rdata[15])
    else $error("plain outputs differ from request");
  a_enable_mask: assert property (
    io_rd && io_addr == ADDR_ENABLES |=> io_rdata[9:8] == 2'h0 && io_rdata[1:0] == 2'h0)
    else $error("ignored enable bits stored");
  a_power_clear: assert property (
    $rose(rst_n) |=> latch_strobe && latch_data == 8'h00)
    else $error("no latch clear after reset");
  a_nmi_needs_en: assert property (
    nmi |-> en_r[15:10] != 6'h00 || $past(en_r[15:10]) != 6'h00)
    else $error("nmi without enable");
  a_update_gate: assert property (
    $past(rst_n, 2) && !upd_r && !$past(upd_r) && !$past(upd_r, 2) |-> !latch_strobe)
    else $error("latch strobe while updates off");
endmodule : pmio_core_asserts

bind pmio_core pmio_core_asserts u_chk (.core_clk, .rst_n, .io_addr, .io_wr, .io_rd,
  .io_wdata, .io_rdata, .serial_a_shadow, .serial_b_shadow, .parallel_reg2_shadow,
  .parallel_reg0_shadow, .latch_data, .latch_strobe, .nmi);

`default_nettype wire

/* File: pmio_far_model.sv */
/*
  Far side: external output latch and processor hold acknowledge.
  Assumes the latch powers up holding junk until the block clears it.
*/
`timescale 1ns/1ps
`default_nettype none

module pmio_far_model #(
  parameter int ACK_DLY = 3  // Cycles before hold is granted.
) (
  input  wire logic       core_clk,
  input  wire logic [7:0] latch_data,
  input  wire logic       latch_strobe,
  input  wire logic       hold_request,
  output var  logic       hold_acknowledge,
  output wire logic [7:0] latch_q
);
  logic [7:0] q_r   = 8'hA5;  // Junk until the first load.
  int         cnt_r = 0;      // Cycles since hold was requested.

  assign latch_q = q_r;

  // The latch loads on the strobe only.
  always_ff @(posedge core_clk) begin
    if (latch_strobe) q_r <= latch_data;
  end

  // Grants hold after a delay and drops it with the request.
  always_ff @(posedge core_clk) begin
    cnt_r <= hold_request ? cnt_r + 1 : 0;
    hold_acknowledge <= hold_request && cnt_r >= ACK_DLY;
  end
endmodule : pmio_far_model

`default_nettype wire

/* File: pmio_pkg.sv */
/*
  Package for the power-management I/O block: port addresses, field
  positions, reset values and timing counts.
  Assumes a 100 MHz core clock and 16-bit host I/O ports.
*/
`default_nettype none

package pmio_pkg;

  // Host I/O port addresses of the seven registers.
  localparam logic [15:0] ADDR_OUT_LOW  = 16'h7072;
  localparam logic [15:0] ADDR_OUT_HIGH = 16'h7872;
  localparam logic [15:0] ADDR_TIMERS   = 16'h8072;
  localparam logic [15:0] ADDR_INPUTS   = 16'h8872;
  localparam logic [15:0] ADDR_STATUS   = 16'h9072;
  localparam logic [15:0] ADDR_ENABLES  = 16'hC872;
  localparam logic [15:0] ADDR_SHADOW   = 16'hD072;

  // Fixed output bit positions in the low output word.
  localparam int OUT_CLK_EN    = 0;
  localparam int OUT_PANEL     = 1;
  localparam int OUT_BACKLIGHT = 2;
  localparam int OUT_LOCAL_ACKNOWLEDGE   = 3;
  localparam int OUT_LCL_ATTN  = 4;
  localparam int OUT_CPU_PD    = 5;
  localparam int OUT_A20       = 6;
  localparam int OUT_FULL_PD   = 7;

  // Control bit positions in the input register.
  localparam int IN_UPDATE_EN  = 15;
  localparam int IN_LOCAL_EN   = 14;
  localparam int IN_AF_LSB     = 8;
  // Enable field positions in the enables register.
  localparam int EN_NMI_LSB    = 10;
  localparam int EN_ATTN_LSB   = 2;
  // Input that carries the local request.
  localparam int IN_LOCAL_REQ  = 2;

  // Special timeout codes.
  localparam logic [7:0] TMO_OFF     = 8'h00;
  localparam logic [7:0] TMO_ALWAYS  = 8'hFF;

  // Reset values.
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;

  // Timeout step in seconds and the clock rate.
  localparam longint STEP_S      = 5;
  localparam longint CLK_HZ      = 100000000;
  localparam longint STEP_CYCLES = STEP_S * CLK_HZ;

  // Local access handshake states.
  typedef enum logic [1:0] {
    LCL_IDLE,
    LCL_HOLD,
    LOCAL_ACKNOWLEDGE
  } pmio_lcl_t;

endpackage : pmio_pkg

`default_nettype wire

/* File: pmio_sync.sv */
/*
  Three-stage input synchroniser for the ten pin inputs of the block.
  Assumes the inputs are asynchronous to core_clk; a change is accepted
  once the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module pmio_sync (
  input  wire logic       core_clk,  // Core clock.
  input  wire logic       rst_n,     // Synchronous reset, active low.
  input  wire logic [9:0] pin_in,    // Raw pin levels.
  output var  logic [9:0] pin_sync   // Filtered, synchronised levels.
);
  import pmio_pkg::*;

  logic [9:0] st1_r;  // First stage, read only by the second.
  logic [9:0] st2_r;  // Second stage.
  logic [9:0] st3_r;  // Third stage.

  // Shift the raw levels through three flip-flops.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st1_r <= 10'h000;
      st2_r <= 10'h000;
      st3_r <= 10'h000;
    end else begin
      st1_r <= pin_in;
      st2_r <= st1_r;
      st3_r <= st2_r;
    end
  end

  // Accept a bit only once the later two stages agree.
  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_agree
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          pin_sync[g] <= 1'b0;
        end else if (st2_r[g] == st3_r[g]) begin
          pin_sync[g] <= st3_r[g];
        end
      end
    end
  endgenerate

endmodule : pmio_sync

`default_nettype wire

/* File: testbench.sv */
/*
  Self-checking bench for pmio_core with the far-side model.
  Assumes a shortened timeout step of 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pmio_pkg::*;
  localparam int STEP = 20;  // Cycles per timeout step.
  logic core_clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic kbd_irq = 1'b0, refresh_cycle = 1'b0, a20_gate = 1'b0;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata, d, v;
  logic [7:0]  power_in = 8'h00, p0 = 8'h00, latch_data, power_out_high, latch_q;
  logic [1:0]  sa = 2'h0, sb = 2'h0;
  logic [3:0]  p2 = 4'h0;
  logic        latch_strobe, hold_request, hold_acknowledge, nmi, attention_signal;
  logic [31:0] seed = 32'hF08E;  // Random state.
  int          n_mismatch = 0, comparisons = 0;

  always #5 core_clk = ~core_clk;

  pmio_core #(.STEP_CYC(STEP)) dut (.core_clk, .rst_n, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .power_in, .kbd_irq, .hold_acknowledge, .refresh_cycle,
    .a20_gate, .serial_a_shadow(sa), .serial_b_shadow(sb), .parallel_reg2_shadow(p2),
    .parallel_reg0_shadow(p0), .latch_data, .latch_strobe, .power_out_high,
    .hold_request, .nmi, .attention_signal);
  pmio_far_model #(.ACK_DLY(5)) far (.core_clk, .latch_data, .latch_strobe,
    .hold_request, .hold_acknowledge, .latch_q);

  // Xorshift step of the random source.
  function logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  // Whether a panel or backlight output is on at elapsed steps el.
  function logic tmo_on(input logic [7:0] lim, input int el);
    return lim == TMO_ALWAYS || (lim != TMO_OFF && el < lim);
  endfunction : tmo_on

  // Low output word read back with ack, attention and A20 low.
  function logic [15:0] exp_low(input logic [7:0] rq, lb, lp, input int el);
    logic [7:0] o;
    o = rq & 8'hA7;
    o[OUT_PANEL] = rq[OUT_PANEL] & tmo_on(lp, el);
    o[OUT_BACKLIGHT] = rq[OUT_BACKLIGHT] & tmo_on(lb, el);
    return {rq, o};
  endfunction : exp_low

  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task wr(input logic [15:0] a, dat);
    cyc(1);
    io_addr = a;
    io_wdata = dat;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, output logic [15:0] dat);
    cyc(1);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    dat = io_rdata;
  endtask : rd

  // Bounded wait for hold_request (sel 0) or the latched ack (sel 1).
  task wait_sig(input string nm, input int sel, input logic lv);
    int i;
    for (i = 0; i < 60 && (sel ? latch_q[OUT_LOCAL_ACKNOWLEDGE] : hold_request) !== lv; i++) cyc(1);
    if ((sel ? latch_q[OUT_LOCAL_ACKNOWLEDGE] : hold_request) !== lv) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, lv,
               (sel ? latch_q[OUT_LOCAL_ACKNOWLEDGE] : hold_request));
      end_sim();
    end
  endtask : wait_sig

  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(3);
    chk("latch clear", latch_q, 16'h0000);
    rd(ADDR_TIMERS, d);
    chk("timers reset", d, RST_WORD);
    rd(16'h1234, d);
    chk("unmapped", d, 16'h0000);
    repeat (4) begin
      v = rnd();
      wr(ADDR_TIMERS, v);
      rd(ADDR_TIMERS, d);
      chk("timers", d, v);
      wr(ADDR_ENABLES, v);
      rd(ADDR_ENABLES, d);
      chk("enables", d, v & 16'hFCFC);
    end
    v = rnd();
    wr(ADDR_OUT_HIGH, v);
    rd(ADDR_OUT_HIGH, d);
    chk("high word", d, {v[15:8], v[15:8]});
    chk("high pins", power_out_high, v[15:8]);
    {sa, sb, p2, p0} = rnd();
    rd(ADDR_SHADOW, d);
    chk("shadow", d, {sa, sb, p2, p0});
    wr(ADDR_ENABLES, 16'h0000);
    power_in = rnd() & 8'h7B;
    cyc(6);
    rd(ADDR_INPUTS, d);
    chk("inputs", d, {8'h00, power_in});
    $display("test registers done");
    wr(ADDR_INPUTS, 16'h8000);
    wr(ADDR_TIMERS, 16'hFF01);
    wr(ADDR_OUT_LOW, 16'hA755);
    kbd_irq = 1'b1;
    cyc(6);
    refresh_cycle = 1'b1;
    cyc(1);
    refresh_cycle = 1'b0;
    rd(ADDR_OUT_LOW, d);
    chk("outputs fresh", d, exp_low(8'hA7, 8'hFF, 8'h01, 0));
    chk("latch fresh", latch_q, exp_low(8'hA7, 8'hFF, 8'h01, 0) & 16'h00FF);
    cyc(STEP + 5);
    rd(ADDR_OUT_LOW, d);
    chk("outputs idle", d, exp_low(8'hA7, 8'hFF, 8'h01, 1));
    wr(ADDR_TIMERS, 16'h00FF);
    rd(ADDR_OUT_LOW, d);
    chk("codes", d, exp_low(8'hA7, 8'h00, 8'hFF, 1));
    cyc(4);
    wr(ADDR_INPUTS, 16'h0000);
    wr(ADDR_OUT_LOW, 16'h0100);
    cyc(4);
    chk("latch held", latch_q, exp_low(8'hA7, 8'h00, 8'hFF, 1) & 16'h00FF);
    wr(ADDR_INPUTS, 16'h8000);
    a20_gate = 1'b1;
    cyc(4);
    chk("latch a20", latch_q, 16'h0041);
    $display("test outputs done");
    wr(ADDR_ENABLES, 16'h0800);
    power_in[3] = ~power_in[3];
    v = {8'h80, power_in};
    cyc(8);
    chk("nmi set", nmi, 1'b1);
    power_in[3] = ~power_in[3];
    cyc(8);
    rd(ADDR_INPUTS, d);
    chk("frozen", d, v);
    wr(ADDR_STATUS, 16'hFFFF);
    rd(ADDR_STATUS, d);
    chk("flag kept", d, 16'h0008);
    wr(ADDR_STATUS, 16'h0000);
    cyc(8);
    rd(ADDR_STATUS, d);
    chk("late edge", d, 16'h0008);
    wr(ADDR_ENABLES, 16'h0000);
    cyc(2);
    rd(ADDR_STATUS, d);
    chk("enable clear", d, 16'h0000);
    chk("nmi clear", nmi, 1'b0);
    power_in[7] = 1'b1;
    cyc(8);
    wr(ADDR_ENABLES, 16'h8000);
    power_in[7] = 1'b0;
    cyc(8);
    rd(ADDR_STATUS, d);
    chk("in7 fall", d, 16'h0000);
    power_in[7] = 1'b1;
    cyc(8);
    rd(ADDR_STATUS, d);
    chk("in7 rise", d, 16'h0080);
    wr(ADDR_ENABLES, 16'h0010);
    power_in[4] = ~power_in[4];
    cyc(8);
    chk("attn enable", attention_signal, 1'b1);
    wr(ADDR_ENABLES, 16'h0000);
    cyc(3);
    chk("attn clear", attention_signal, 1'b0);
    wr(ADDR_INPUTS, 16'h8400);
    power_in[4] = ~power_in[4];
    cyc(8);
    chk("attn flag", attention_signal, 1'b1);
    wr(ADDR_STATUS, 16'h0000);
    cyc(3);
    chk("flag zero", attention_signal, 1'b0);
    $display("test events done");
    wr(ADDR_INPUTS, 16'hC000);
    power_in[2] = 1'b1;
    wait_sig("hold up", 0, 1'b1);
    wait_sig("ack up", 1, 1'b1);
    power_in[2] = 1'b0;
    wait_sig("ack down", 1, 1'b0);
    chk("hold down", hold_request, 1'b0);
    $display("test local done");
    end_sim();
  end
endmodule : testbench

`default_nettype wire
